//--- rtl/ssbs_pkg.sv
// constants and types shared by the status and brake sequencer files
package ssbs_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_TOL = 16'h3359;
  localparam logic [15:0] IDX_ROT = 16'h335B;
  localparam logic [15:0] IDX_DEV = 16'h335C;
  localparam logic [15:0] IDX_ON_WAIT = 16'h335D;
  localparam logic [15:0] IDX_OFF_WAIT = 16'h335E;
  localparam logic [15:0] IDX_BRK_SPD = 16'h335F;
  localparam logic [15:0] IDX_BRK_WAIT = 16'h3360;
  localparam logic [15:0] IDX_IN_MAP = 16'h3361;
  localparam logic [15:0] IDX_CTRL = 16'h3370;
  localparam logic [15:0] IDX_STAT = 16'h3371;
  // reset values
  localparam logic [15:0] RST_TOL = 16'h000A;
  localparam logic [15:0] RST_ROT = 16'h0014;
  localparam logic [31:0] RST_DEV = 32'h0280_0000;
  localparam logic [15:0] RST_ON_WAIT = 16'h0000;
  localparam logic [15:0] RST_OFF_WAIT = 16'h0000;
  localparam logic [15:0] RST_BRK_SPD = 16'h0064;
  localparam logic [15:0] RST_BRK_WAIT = 16'h0032;
  localparam logic [15:0] RST_IN_MAP = 16'h3210;
  localparam logic RST_BRAKE_FN = 1'b1;
  // control and status field positions
  localparam int CTRL_BRAKE_FN = 0;
  localparam int CTRL_ALM_CLR = 1;
  localparam int CTRL_RESTART = 2;
  localparam int STAT_MATCH = 0;
  localparam int STAT_ROT = 1;
  localparam int STAT_ALM = 2;
  localparam int STAT_BRK = 3;
  localparam int STAT_EXC = 4;
  localparam int STAT_STATE = 8;
  // timing
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam logic [31:0] UNIT_MS = 32'h0000_000A;
  localparam int N_TERM = 4;
  localparam int N_FUNC = 8;
  typedef enum logic [2:0] {
    SSBS_OFF = 3'b000,
    SSBS_PRE = 3'b001,
    SSBS_RUN = 3'b010,
    SSBS_COAST = 3'b011,
    SSBS_HOLD = 3'b100
  } ssbs_state_t;
endpackage

//--- rtl/ssbs_reg_if.sv
// register access carrier between bus slave and register file
`timescale 1ns/1ps
interface ssbs_reg_if;
  logic wr;
  logic [15:0] widx;
  logic [31:0] wdata;
  logic [15:0] ridx;
  logic [31:0] rdata;
  modport slave (output wr, output widx, output wdata, output ridx,
    input rdata);
  modport regs (input wr, input widx, input wdata, input ridx,
    output rdata);
endinterface

//--- rtl/ssbs_tick.sv
// millisecond enable pulse divider
`timescale 1ns/1ps
module ssbs_tick
#(
  parameter int unsigned DIV = ssbs_pkg::MS_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // one-cycle pulse every DIV cycles
  output logic tick
);
  import ssbs_pkg::*;
  typedef struct packed
  {
    logic [31:0] cnt;
    logic tick;
  } ssbs_tick_st_t;
  ssbs_tick_st_t s_r;
  ssbs_tick_st_t s_nxt;

  // refused at elaboration: a zero divider would never pulse
  if (DIV < 1)
    $error("divider must be at least one");

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= DIV - 1)
    begin
      s_nxt.cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.cnt = s_r.cnt + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;
endmodule

//--- rtl/ssbs_ahb.sv
// AHB-Lite slave front end, one wait state on reads
`timescale 1ns/1ps
module ssbs_ahb
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // register side
  ssbs_reg_if.slave rif
);
  import ssbs_pkg::*;
  typedef struct packed
  {
    logic wpend;
    logic rpend;
    logic [15:0] idx;
    logic [31:0] rdata;
  } ssbs_ahb_st_t;
  ssbs_ahb_st_t s_r;
  ssbs_ahb_st_t s_nxt;
  logic take;

  // only whole-word accesses reach the registers
  assign take = hsel && htrans[1] && hready && (hsize == 3'h2);

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wpend = 1'b0;
    if (s_r.rpend)
    begin
      s_nxt.rdata = rif.rdata;
      s_nxt.rpend = 1'b0;
    end
    if (take)
    begin
      s_nxt.idx = haddr[17:2];
      s_nxt.wpend = hwrite;
      s_nxt.rpend = !hwrite;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // the read is sampled a cycle late so a preceding write is seen
  assign rif.ridx = s_r.idx;
  assign rif.wr = s_r.wpend;
  assign rif.widx = s_r.idx;
  assign rif.wdata = hwdata;
  assign hrdata = s_r.rdata;
  assign hreadyout = !s_r.rpend;
  assign hresp = 1'b0;

  AST_RD_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule

//--- rtl/ssbs_top.sv
// servo status detection and holding brake sequencer
`timescale 1ns/1ps
module ssbs_top
#(
  parameter int unsigned MS_DIV = ssbs_pkg::MS_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // AHB-Lite register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // drive feedback, same clock
  input wire logic signed [15:0] SPEED_REF,
  input wire logic signed [15:0] SPEED_FB,
  input wire logic signed [31:0] POS_DEV,
  // pins
  input wire logic SERVO_ON_REQ,
  input wire logic [3:0] DIN,
  // status outputs
  output logic SPEED_MATCH_OUT,
  output logic ROTATION_DETECT_OUT,
  output logic DEV_OVERFLOW_ALARM,
  // brake and power stage
  output logic HOLDING_BRAKE_OUT,
  output logic MOTOR_EXCITE,
  // mapped input functions
  output logic [7:0] IN_FUNC
);
  import ssbs_pkg::*;
  typedef struct packed
  {
    logic [15:0] tol;
    logic [15:0] rot;
    logic [31:0] dev;
    logic [15:0] on_w;
    logic [15:0] off_w;
    logic [15:0] bspd;
    logic [15:0] bwait;
    logic [15:0] map;
    logic [15:0] map_act;
    logic brake_fn;
    logic [4:0] sync1;
    logic [4:0] sync2;
    ssbs_state_t st;
    logic [31:0] tmr;
    logic match;
    logic rotd;
    logic alm;
    logic brk;
    logic exc;
    logic [7:0] func;
  } ssbs_st_t;
  ssbs_st_t s_r;
  ssbs_st_t s_nxt;
  ssbs_reg_if rif ();
  logic ms_tick;
  logic [16:0] fb_mag;
  logic [16:0] err_mag;
  logic [31:0] dev_mag;
  logic [15:0] on_abs;
  logic [31:0] off_lim;
  logic [31:0] bwait_lim;
  logic match_cond;
  logic rot_cond;
  logic alm_cond;
  logic servo_on;
  logic alm_clr;
  logic restart;
  logic [31:0] rd;

  function automatic logic [16:0] mag17(input logic [16:0] v);
    mag17 = v[16] ? 17'(-v) : v;
  endfunction

  ssbs_ahb u_ahb
  (
    .clk(CLK),
    .rst_n(RESET_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .rif(rif)
  );

  ssbs_tick #(.DIV(MS_DIV)) u_tick
  (
    .clk(CLK),
    .rst_n(RESET_N),
    .tick(ms_tick)
  );

  // speeds as magnitudes so both directions behave alike
  assign fb_mag = mag17({SPEED_FB[15], SPEED_FB});
  assign err_mag = mag17(17'({SPEED_REF[15], SPEED_REF})
    - 17'({SPEED_FB[15], SPEED_FB}));
  assign dev_mag = POS_DEV[31] ? 32'(-POS_DEV) : POS_DEV;
  assign on_abs = s_r.on_w[15] ? 16'(-s_r.on_w) : s_r.on_w;
  assign off_lim = 32'({16'h0, s_r.off_w} * UNIT_MS);
  assign bwait_lim = 32'({16'h0, s_r.bwait} * UNIT_MS);
  // live register values feed the comparators
  assign match_cond = err_mag < {1'b0, s_r.tol};
  assign rot_cond = fb_mag > {1'b0, s_r.rot};
  assign alm_cond = dev_mag > s_r.dev;
  assign servo_on = s_r.sync2[4];
  assign alm_clr = rif.wr && rif.widx == IDX_CTRL
    && rif.wdata[CTRL_ALM_CLR];
  assign restart = rif.wr && rif.widx == IDX_CTRL
    && rif.wdata[CTRL_RESTART];

  always_comb
  begin
    unique case (rif.ridx)
      IDX_TOL: rd = {16'h0, s_r.tol};
      IDX_ROT: rd = {16'h0, s_r.rot};
      IDX_DEV: rd = s_r.dev;
      IDX_ON_WAIT: rd = {16'h0, s_r.on_w};
      IDX_OFF_WAIT: rd = {16'h0, s_r.off_w};
      IDX_BRK_SPD: rd = {16'h0, s_r.bspd};
      IDX_BRK_WAIT: rd = {16'h0, s_r.bwait};
      IDX_IN_MAP: rd = {16'h0, s_r.map};
      IDX_CTRL: rd = {31'h0, s_r.brake_fn};
      IDX_STAT: rd = {21'h0, s_r.st, 3'h0, s_r.exc, s_r.brk, s_r.alm,
        s_r.rotd, s_r.match};
      default: rd = 32'h0;
    endcase
  end
  assign rif.rdata = rd;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = {SERVO_ON_REQ, DIN};
    s_nxt.sync2 = s_r.sync1;
    if (rif.wr)
    begin
      unique case (rif.widx)
        IDX_TOL: s_nxt.tol = rif.wdata[15:0];
        IDX_ROT: s_nxt.rot = rif.wdata[15:0];
        IDX_DEV: s_nxt.dev = rif.wdata;
        IDX_ON_WAIT: s_nxt.on_w = rif.wdata[15:0];
        IDX_OFF_WAIT: s_nxt.off_w = rif.wdata[15:0];
        IDX_BRK_SPD: s_nxt.bspd = rif.wdata[15:0];
        IDX_BRK_WAIT: s_nxt.bwait = rif.wdata[15:0];
        IDX_IN_MAP: s_nxt.map = rif.wdata[15:0];
        IDX_CTRL: s_nxt.brake_fn = rif.wdata[CTRL_BRAKE_FN];
        default: s_nxt.tol = s_r.tol;
      endcase
    end
    // a new map is only adopted at restart
    if (restart)
      s_nxt.map_act = s_r.map;
    s_nxt.match = match_cond;
    s_nxt.rotd = rot_cond;
    // set wins over a clear in the same cycle
    s_nxt.alm = alm_cond || (s_r.alm && !alm_clr);
    for (int f = 0; f < N_FUNC; f++)
    begin
      s_nxt.func[f] = 1'b0;
      for (int t = 0; t < N_TERM; t++)
        if (s_r.sync2[t] && s_r.map_act[4*t +: 3] == 3'(f))
          s_nxt.func[f] = 1'b1;
    end
    if (ms_tick)
      s_nxt.tmr = s_r.tmr + 32'h1;
    unique case (s_r.st)
      SSBS_OFF:
      begin
        s_nxt.tmr = 32'h0;
        s_nxt.brk = 1'b0;
        s_nxt.exc = 1'b0;
        if (servo_on)
        begin
          if (!s_r.brake_fn)
          begin
            s_nxt.exc = 1'b1;
            s_nxt.st = SSBS_RUN;
          end
          else if (!s_r.on_w[15] && s_r.on_w != 16'h0)
          begin
            s_nxt.brk = 1'b1;
            s_nxt.st = SSBS_PRE;
          end
          else if (s_r.on_w[15])
          begin
            s_nxt.exc = 1'b1;
            s_nxt.st = SSBS_PRE;
          end
          else
          begin
            s_nxt.brk = 1'b1;
            s_nxt.exc = 1'b1;
            s_nxt.st = SSBS_RUN;
          end
        end
      end
      SSBS_PRE:
      begin
        if (!servo_on)
        begin
          s_nxt.brk = 1'b0;
          s_nxt.exc = 1'b0;
          s_nxt.st = SSBS_OFF;
        end
        else if (s_r.tmr >= {16'h0, on_abs})
        begin
          s_nxt.brk = 1'b1;
          s_nxt.exc = 1'b1;
          s_nxt.st = SSBS_RUN;
        end
      end
      SSBS_RUN:
      begin
        s_nxt.tmr = 32'h0;
        if (!servo_on)
        begin
          if (!s_r.brake_fn)
          begin
            s_nxt.exc = 1'b0;
            s_nxt.brk = 1'b0;
            s_nxt.st = SSBS_OFF;
          end
          else if (!s_r.rotd)
          begin
            s_nxt.brk = 1'b0;
            s_nxt.st = SSBS_HOLD;
          end
          else
          begin
            s_nxt.exc = 1'b0;
            s_nxt.st = SSBS_COAST;
          end
        end
      end
      SSBS_HOLD:
      begin
        if (s_r.tmr >= off_lim)
        begin
          s_nxt.exc = 1'b0;
          s_nxt.st = SSBS_OFF;
        end
      end
      SSBS_COAST:
      begin
        // speed or elapsed time, whichever first
        if (fb_mag < {1'b0, s_r.bspd} || s_r.tmr > bwait_lim)
        begin
          s_nxt.brk = 1'b0;
          s_nxt.st = SSBS_OFF;
        end
      end
      default:
      begin
        s_nxt.brk = 1'b0;
        s_nxt.exc = 1'b0;
        s_nxt.st = SSBS_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_r <= '0;
      s_r.tol <= RST_TOL;
      s_r.rot <= RST_ROT;
      s_r.dev <= RST_DEV;
      s_r.on_w <= RST_ON_WAIT;
      s_r.off_w <= RST_OFF_WAIT;
      s_r.bspd <= RST_BRK_SPD;
      s_r.bwait <= RST_BRK_WAIT;
      s_r.map <= RST_IN_MAP;
      s_r.map_act <= RST_IN_MAP;
      s_r.brake_fn <= RST_BRAKE_FN;
      s_r.st <= SSBS_OFF;
    end
    else
      s_r <= s_nxt;
  end

  assign SPEED_MATCH_OUT = s_r.match;
  assign ROTATION_DETECT_OUT = s_r.rotd;
  assign DEV_OVERFLOW_ALARM = s_r.alm;
  assign HOLDING_BRAKE_OUT = s_r.brk;
  assign MOTOR_EXCITE = s_r.exc;
  assign IN_FUNC = s_r.func;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence seq_on_start;
    s_r.st == SSBS_OFF && servo_on && s_r.brake_fn;
  endsequence
  sequence seq_coast_slow;
    s_r.st == SSBS_COAST && fb_mag < {1'b0, s_r.bspd};
  endsequence

  AST_MATCH: assert property ($past(RESET_N) |->
    SPEED_MATCH_OUT == $past(match_cond)) else $error("speed match wrong");
  AST_ROT: assert property ($past(RESET_N) |->
    ROTATION_DETECT_OUT == $past(rot_cond)) else $error("rotation wrong");
  AST_ALM: assert property (alm_cond |=> DEV_OVERFLOW_ALARM)
    else $error("overflow alarm not raised");
  AST_POS_WAIT: assert property (seq_on_start ##0 !s_r.on_w[15]
    && s_r.on_w != 16'h0 |=> HOLDING_BRAKE_OUT && !MOTOR_EXCITE)
    else $error("brake not released before excitation");
  AST_NEG_WAIT: assert property (seq_on_start ##0 s_r.on_w[15]
    |=> MOTOR_EXCITE && !HOLDING_BRAKE_OUT)
    else $error("excitation not first");
  AST_NO_FN: assert property (!s_r.brake_fn && s_r.st == SSBS_RUN
    |-> !HOLDING_BRAKE_OUT)
    else $error("brake timing used while function off");
  AST_HOLD: assert property (s_r.st == SSBS_HOLD
    |-> !HOLDING_BRAKE_OUT && MOTOR_EXCITE)
    else $error("stopped servo off sequence wrong");
  AST_SPEED_REL: assert property (seq_coast_slow
    |=> s_r.st == SSBS_OFF && !HOLDING_BRAKE_OUT)
    else $error("brake not applied below speed");
  AST_TIME_REL: assert property (s_r.st == SSBS_COAST
    && s_r.tmr > bwait_lim |=> !HOLDING_BRAKE_OUT)
    else $error("brake not applied after wait");
  AST_MAP: assert property (!restart |=> $stable(s_r.map_act))
    else $error("input map changed without restart");
endmodule

//--- sim/ssbs_motor_model.sv
// behavioural motor shaft with holding brake, far side of the sequencer
`timescale 1ns/1ps
module ssbs_motor_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // brake and power stage commands
  input wire logic brake_rel,
  input wire logic excite,
  // speed the drive holds while powered, coast loss per cycle
  input wire logic signed [15:0] target,
  input wire logic [15:0] decel,
  // shaft speed in rpm
  output logic signed [15:0] speed
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      speed <= 16'sh0000;
    else if (excite)
      speed <= target;
    // an engaged brake stops the shaft at once, harsher than a real load
    else if (!brake_rel)
      speed <= 16'sh0000;
    else if (speed > $signed(decel))
      speed <= speed - $signed(decel);
    else
      speed <= 16'sh0000;
  end
endmodule

//--- sim/ssbs_tb.sv
// self-checking bench for the status detection and brake sequencer
`timescale 1ns/1ps
module testbench;
  import ssbs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic signed [15:0] sref = 16'sh0000;
  logic signed [15:0] fb_drv = 16'sh0000;
  logic signed [15:0] tgt = 16'sh0000;
  logic signed [15:0] mfb;
  logic signed [31:0] pdev = 32'sh0;
  logic son = 1'b0;
  logic [3:0] din = 4'h0;
  logic direct = 1'b1;
  logic [15:0] decel = 16'h000A;
  logic sm, rot, alm, brk, exc;
  logic [7:0] func;
  int err_total = 0;
  int compares = 0;
  always #5 clk = ~clk;
  ssbs_top #(.MS_DIV(4)) ssbs_top_inst (.CLK(clk), .RESET_N(rst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .SPEED_REF(sref),
    .SPEED_FB(direct ? fb_drv : mfb), .POS_DEV(pdev),
    .SERVO_ON_REQ(son), .DIN(din), .SPEED_MATCH_OUT(sm),
    .ROTATION_DETECT_OUT(rot), .DEV_OVERFLOW_ALARM(alm),
    .HOLDING_BRAKE_OUT(brk), .MOTOR_EXCITE(exc), .IN_FUNC(func));
  ssbs_motor_model ssbs_motor_model_inst (.clk(clk), .rst_n(rst_n),
    .brake_rel(brk), .excite(exc), .target(tgt), .decel(decel),
    .speed(mfb));
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi,
    input int g);
    compares++;
    if (g < lo || g > hi)
    begin
      err_total++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // entered just after a rising edge; holds each phase until hready
  task automatic bus(input logic w, input logic [15:0] ix,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {14'h0, ix, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ix, d, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for brake (b=1) or excite (b=0) to reach v
  task automatic waitv(input bit b, input logic v, output int n);
    n = 0;
    while (((b ? brk : exc) !== v) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    // a wait that runs out is a mismatch of its own
    if (n >= 3000)
    begin
      err_total++;
      $display("FAIL wait limit expected below 3000 seen %0d", n);
    end
  endtask
  task automatic t_regs;
    logic [15:0] ix [8] = '{IDX_TOL, IDX_ROT, IDX_DEV, IDX_ON_WAIT,
      IDX_OFF_WAIT, IDX_BRK_SPD, IDX_BRK_WAIT, IDX_IN_MAP};
    logic [31:0] rv [8] = '{32'h000A, 32'h0014, 32'h0280_0000, 32'h0,
      32'h0, 32'h0064, 32'h0032, 32'h3210};
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, ix[i], 32'h0, d);
      chk("reset value", rv[i], d);
    end
    bus(1'b0, 16'h3380, 32'h0, d);
    chk("unmapped", 32'h0, d);
    chk("hresp okay", 32'h0, hresp);
    wr(IDX_TOL, 32'h0005);
    bus(1'b0, IDX_TOL, 32'h0, d);
    chk("tol readback", 32'h0005, d);
  endtask
  task automatic t_status;
    logic [15:0] rf [6] = '{16'h0064, 16'h0064, 16'hFFE2, 16'h0000,
      16'h0000, 16'h0003};
    logic [15:0] fb [6] = '{16'h0060, 16'h005F, 16'hFFE6, 16'h0014,
      16'hFFEB, 16'h0000};
    logic [1:0] ex [6] = '{2'h3, 2'h2, 2'h3, 2'h0, 2'h2, 2'h1};
    for (int i = 0; i < 6; i++)
    begin
      sref <= rf[i];
      fb_drv <= fb[i];
      cyc(3);
      chk("speed match", ex[i][0], sm);
      chk("rotation", ex[i][1], rot);
    end
    fb_drv <= 16'h0000;
  endtask
  task automatic t_alarm;
    wr(IDX_DEV, 32'h0064);
    pdev <= 32'sh64;
    cyc(3);
    chk("alarm at limit", 1'b0, alm);
    pdev <= -32'sh65;
    cyc(3);
    chk("alarm over", 1'b1, alm);
    pdev <= 32'sh0;
    cyc(3);
    chk("alarm sticky", 1'b1, alm);
    wr(IDX_CTRL, 32'h0003);
    cyc(2);
    chk("alarm cleared", 1'b0, alm);
  endtask
  task automatic t_map;
    din <= 4'h1;
    cyc(5);
    chk("func default", 8'h01, func);
    wr(IDX_IN_MAP, 32'h0123);
    cyc(4);
    chk("func no restart", 8'h01, func);
    wr(IDX_CTRL, 32'h0005);
    cyc(4);
    chk("func restart", 8'h08, func);
    din <= 4'h0;
  endtask
  task automatic t_seq;
    int n;
    logic [31:0] d;
    direct <= 1'b0;
    wr(IDX_ON_WAIT, 32'h0003);
    wr(IDX_OFF_WAIT, 32'h0001);
    son <= 1'b1;
    waitv(1, 1'b1, n);
    chk("excite held", 1'b0, exc);
    waitv(0, 1'b1, n);
    rng("on wait", 8, 17, n);
    son <= 1'b0;
    waitv(1, 1'b0, n);
    chk("power kept", 1'b1, exc);
    waitv(0, 1'b0, n);
    rng("off wait", 34, 46, n);
    wr(IDX_ON_WAIT, 32'hFFFD);
    son <= 1'b1;
    waitv(0, 1'b1, n);
    chk("brake held", 1'b0, brk);
    waitv(1, 1'b1, n);
    rng("neg on wait", 8, 17, n);
    tgt <= 16'sh03E8;
    cyc(6);
    son <= 1'b0;
    waitv(0, 1'b0, n);
    chk("brake kept", 1'b1, brk);
    bus(1'b0, IDX_STAT, 32'h0, d);
    chk("status coast", 32'h0000_030A, d);
    waitv(1, 1'b0, n);
    rng("brake speed", 50, 99, mfb);
    wr(IDX_BRK_SPD, 32'h000A);
    wr(IDX_BRK_WAIT, 32'h000A);
    decel <= 16'h0001;
    son <= 1'b1;
    waitv(1, 1'b1, n);
    cyc(6);
    son <= 1'b0;
    waitv(0, 1'b0, n);
    waitv(1, 1'b0, n);
    rng("brake time", 390, 415, n);
    tgt <= 16'sh0000;
    wr(IDX_CTRL, 32'h0000);
    wr(IDX_ON_WAIT, 32'h0003);
    son <= 1'b1;
    waitv(0, 1'b1, n);
    rng("no brake fn", 0, 6, n);
    chk("brake idle", 1'b0, brk);
    son <= 1'b0;
    waitv(0, 1'b0, n);
    wr(IDX_CTRL, 32'h0001);
  endtask
  // the verdict is printed in this one place only
  task automatic complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_status;
    t_alarm;
    t_map;
    t_seq;
    complete_run;
  end
  // whole run needs some 800 cycles; fifty times that means a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    complete_run;
  end
endmodule
